// >>> pfm_pkg.sv
package pfm_pkg;
   // register byte offsets
   localparam logic [7:0] OFF_CTRL     = 8'h00;
   localparam logic [7:0] OFF_STATUS   = 8'h04;
   localparam logic [7:0] OFF_TIME     = 8'h08;
   localparam logic [7:0] OFF_SENSE    = 8'h0c;
   localparam logic [7:0] OFF_INT_STAT = 8'h10;
   localparam logic [7:0] OFF_INT_CLR  = 8'h14;
   localparam logic [7:0] OFF_INT_EN   = 8'h18;
   localparam logic [7:0] OFF_HIST     = 8'h1c;
   // control fields and reset values
   localparam int         CTRL_EXC_DIS = 0;
   localparam int         CTRL_ONLINE  = 1;
   localparam logic [1:0] CTRL_RST     = 2'h0;
   localparam logic [1:0] INT_RST      = 2'h0;
   localparam int         INT_PRED     = 0;
   localparam int         INT_DONE     = 1;
   // reporting codes
   localparam logic [7:0]  LOG_PAGE_TIME = 8'h3e;
   localparam logic [23:0] SENSE_PRED    = 24'h015d00;
   // timing: one tick is one millisecond
   localparam int CLK_PERIOD_NS  = 10;
   localparam int TICK_NS        = 1000000;
   localparam int TICK_CYC       = TICK_NS / CLK_PERIOD_NS;
   localparam int PERIOD_HOURS   = 2;
   localparam int PERIOD_MS      = PERIOD_HOURS * 3600 * 1000;
   localparam int MEAS_ONLINE_MS = 65;
   localparam int MEAS_FULL_MS   = 490;
   // attribute event carrier
   localparam int ATTR_W = 2;
   typedef struct packed {
      logic              valid;
      logic              err;
      logic [ATTR_W-1:0] attr;
   } pfm_op_s;
   typedef enum {ST_IDLE, ST_WAIT, ST_MEAS} pfm_state_e;
endpackage

// >>> pfm_monitor.sv
// Our own choices: the register addresses and register access over APB.
`timescale 1ns/10ps
`default_nettype none
module pfm_monitor #(
   parameter int NATTR  = 4,
   parameter int OPS_W  = 16,
   parameter int HIST_W = 8,
   parameter int TICK_CYCLES = pfm_pkg::TICK_CYC,
   parameter int PERIOD_TICKS = pfm_pkg::PERIOD_MS,
   parameter logic [NATTR-1:0][OPS_W-1:0]  INTERVAL_LEN = '{default: 16'd1000},
   parameter logic [NATTR-1:0][OPS_W-1:0]  ERR_THR      = '{default: 16'd10},
   parameter logic [NATTR-1:0][HIST_W-1:0] PRED_THR     = '{default: 8'd20}
) (
   input  wire logic             i_mclk,       // 100 MHz clock
   input  wire logic             i_sys_rst,    // sync reset, high
   input  wire logic             i_psel,       // apb select
   input  wire logic             i_penable,    // apb enable
   input  wire logic             i_pwrite,     // apb write
   input  wire logic [7:0]       i_paddr,      // apb byte address
   input  wire logic [31:0]      i_pwdata,     // apb write data
   output logic      [31:0]      o_prdata,     // apb read data
   output logic                  o_pready,     // apb ready
   output logic                  o_pslverr,    // apb error
   input  wire pfm_pkg::pfm_op_s i_op,         // completed operation
   input  wire logic             i_bus_idle,   // host bus idle
   input  wire logic             i_rtz,        // return-to-zero pulse
   input  wire logic             i_log_req,    // log sense request
   input  wire logic [7:0]       i_log_page,   // requested page
   output logic                  o_log_valid,  // log answer strobe
   output logic                  o_log_hit,    // page was known
   output logic      [31:0]      o_log_data,   // ms to next measure
   input  wire logic             i_nv_pred,    // stored failure code
   output logic                  o_nv_pred,    // failure code to store
   output logic      [23:0]      o_sense,      // pending sense code
   output logic                  o_meas,       // measurement running
   output logic                  o_offline,    // off-line part active
   output logic                  o_irq         // interrupt, high
);
   import pfm_pkg::*;

   localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);
   localparam logic [31:0] PERIOD_LD = 32'(PERIOD_TICKS);

   // decode for the error answer only; the read mux decodes in its own case
   function automatic logic addr_ok(input logic [7:0] a);
      addr_ok = (a == OFF_CTRL) || (a == OFF_STATUS) || (a == OFF_TIME) ||
                (a == OFF_SENSE) || (a == OFF_INT_STAT) || (a == OFF_INT_CLR) ||
                (a == OFF_INT_EN) || (a == OFF_HIST);
   endfunction

   logic       [1:0]  ctrl_q, ctrl_d;
   logic       [1:0]  ist_q, ist_d;
   logic       [1:0]  ien_q, ien_d;
   logic       [31:0] prdata_q, prdata_d;
   logic       [31:0] tick_q, tick_d;
   logic       [31:0] left_q, left_d;
   logic       [31:0] dur_q, dur_d;
   logic              full_q, full_d;
   pfm_state_e        st_q, st_d;
   logic              pred_q, pred_d;
   logic              boot_q;
   logic              log_v_q, log_h_q, log_v_d, log_h_d;
   logic       [31:0] log_q, log_d;
   logic       [23:0] sense_q, sense_d;
   logic              wr, setup, tick, en, meas_done, online_sel;
   logic [NATTR-1:0]  pf_hit;
   logic [NATTR*HIST_W-1:0] hist_all;

   assign en    = !ctrl_q[CTRL_EXC_DIS];
   assign wr    = i_psel && i_penable && i_pwrite;
   assign setup = i_psel && !i_penable;
   assign tick  = (tick_q == TICK_LAST);
   assign meas_done = (st_q == ST_MEAS) && tick && (dur_q == 32'h1);

   // apb slave: zero wait, read data captured in setup
   always_comb begin
      ctrl_d   = ctrl_q;
      ien_d    = ien_q;
      prdata_d = prdata_q;
      if (wr && i_paddr == OFF_CTRL) begin
         ctrl_d = i_pwdata[1:0];
      end
      if (wr && i_paddr == OFF_INT_EN) begin
         ien_d = i_pwdata[1:0];
      end
      if (setup) begin
         unique case (i_paddr)
            OFF_CTRL:     prdata_d = {30'h0, ctrl_q};
            OFF_STATUS:   prdata_d = {32'(pf_hit) << 8} | {29'h0, pred_q, st_q == ST_WAIT, st_q == ST_MEAS};
            OFF_TIME:     prdata_d = left_q;
            OFF_SENSE:    prdata_d = {8'h0, sense_q};
            OFF_INT_STAT: prdata_d = {30'h0, ist_q};
            OFF_INT_EN:   prdata_d = {30'h0, ien_q};
            OFF_HIST:     prdata_d = 32'(hist_all);
            default:      prdata_d = 32'h0;
         endcase
      end
   end

   assign o_prdata  = prdata_q;
   assign o_pready  = 1'b1;
   assign o_pslverr = i_psel && i_penable && !addr_ok(i_paddr);

   // sticky events, a set in the clear cycle wins
   always_comb begin
      ist_d = ist_q;
      if (wr && i_paddr == OFF_INT_CLR) begin
         ist_d = ist_q & ~i_pwdata[1:0];
      end
      ist_d[INT_PRED] = ist_d[INT_PRED] | (|pf_hit);
      ist_d[INT_DONE] = ist_d[INT_DONE] | meas_done;
   end

   assign o_irq = |(ist_q & ien_q);

   // millisecond divider runs free so timing stays steady
   always_comb begin
      tick_d = tick ? 32'h0 : tick_q + 32'h1;
   end

   // measurement scheduler
   always_comb begin
      st_d   = st_q;
      left_d = left_q;
      dur_d  = dur_q;
      full_d = full_q;
      if (tick && left_q != 32'h0) begin
         left_d = left_q - 32'h1;
      end
      unique case (st_q)
         ST_IDLE: begin
            // a save longer than the period leaves the timer at zero: go wait at once, never stall
            if (i_rtz) begin
               st_d   = ST_MEAS;
               left_d = PERIOD_LD;
               full_d = !ctrl_q[CTRL_ONLINE];
               dur_d  = ctrl_q[CTRL_ONLINE] ? 32'(MEAS_ONLINE_MS) : 32'(MEAS_FULL_MS);
            end else if (left_q == 32'h0 || (tick && left_q == 32'h1)) begin
               st_d = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (i_rtz || i_bus_idle) begin
               st_d   = ST_MEAS;
               left_d = PERIOD_LD;
               full_d = !ctrl_q[CTRL_ONLINE];
               dur_d  = ctrl_q[CTRL_ONLINE] ? 32'(MEAS_ONLINE_MS) : 32'(MEAS_FULL_MS);
            end
         end
         ST_MEAS: begin
            // no exit but the duration count: the save cannot be cut short
            if (tick) begin
               dur_d = dur_q - 32'h1;
               if (dur_q == 32'h1) begin
                  st_d = ST_IDLE;
               end
            end
         end
      endcase
      // disable parks the schedule, except a save already under way
      if (!en && st_q != ST_MEAS) begin
         st_d   = ST_IDLE;
         left_d = PERIOD_LD;
      end
   end

   assign o_meas    = (st_q == ST_MEAS);
   assign o_offline = (st_q == ST_MEAS) && full_q;

   // per-attribute rate counters and failure history
   for (genvar g = 0; g < NATTR; g++) begin : g_attr
      logic [OPS_W-1:0]  ops_q, ops_d, err_q, err_d, ops_n, err_n;
      logic [HIST_W-1:0] hist_q, hist_d;
      logic              hit, bad, done;
      always_comb begin
         hit    = en && i_op.valid && (i_op.attr == ATTR_W'(g));
         ops_n  = ops_q + OPS_W'(1);
         err_n  = err_q + OPS_W'(i_op.err);
         done   = hit && (ops_n == INTERVAL_LEN[g]);
         bad    = err_n > ERR_THR[g];
         ops_d  = ops_q;
         err_d  = err_q;
         hist_d = hist_q;
         if (done) begin
            ops_d = '0;
            err_d = '0;
            if (bad) begin
               hist_d = (hist_q == PRED_THR[g]) ? hist_q : hist_q + HIST_W'(1);
            end else if (hist_q != '0) begin
               hist_d = hist_q - HIST_W'(1);
            end
         end else if (hit) begin
            ops_d = ops_n;
            err_d = err_n;
         end
      end
      always_ff @(posedge i_mclk) begin
         if (i_sys_rst) begin
            ops_q  <= '0;
            err_q  <= '0;
            hist_q <= '0;
         end else begin
            ops_q  <= ops_d;
            err_q  <= err_d;
            hist_q <= hist_d;
         end
      end
      assign pf_hit[g] = done && bad && (hist_d == PRED_THR[g]) && (hist_q != PRED_THR[g]);
      assign hist_all[g*HIST_W +: HIST_W] = hist_q;
   end

   // failure code: only a system reset clears it, stored copy reloads it
   always_comb begin
      pred_d = pred_q | (|pf_hit);
      if (!boot_q && i_nv_pred) begin
         pred_d = 1'b1;
      end
   end

   assign o_nv_pred = pred_q;
   assign o_sense   = sense_q;
   assign o_log_valid = log_v_q;
   assign o_log_hit   = log_h_q;
   assign o_log_data  = log_q;

   // log sense answer and sense code, one cycle behind their causes
   always_comb begin
      log_v_d = i_log_req;
      log_h_d = i_log_req && (i_log_page == LOG_PAGE_TIME);
      log_d   = log_h_d ? left_q : 32'h0;
      sense_d = pred_q ? SENSE_PRED : 24'h0;
   end

   // all state registers but the per-attribute counters and history
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         ctrl_q   <= CTRL_RST;
         ist_q    <= INT_RST;
         ien_q    <= INT_RST;
         prdata_q <= 32'h0;
         tick_q   <= 32'h0;
         left_q   <= PERIOD_LD;
         dur_q    <= 32'h0;
         full_q   <= 1'b0;
         st_q     <= ST_IDLE;
         pred_q   <= 1'b0;
         boot_q   <= 1'b0;
         log_v_q  <= 1'b0;
         log_h_q  <= 1'b0;
         log_q    <= 32'h0;
         sense_q  <= 24'h0;
      end else begin
         ctrl_q   <= ctrl_d;
         ist_q    <= ist_d;
         ien_q    <= ien_d;
         prdata_q <= prdata_d;
         tick_q   <= tick_d;
         left_q   <= left_d;
         dur_q    <= dur_d;
         full_q   <= full_d;
         st_q     <= st_d;
         pred_q   <= pred_d;
         boot_q   <= 1'b1;
         log_v_q  <= log_v_d;
         log_h_q  <= log_h_d;
         log_q    <= log_d;
         sense_q  <= sense_d;
      end
   end

   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_sys_rst);

   property p_dis_idle;
      !en && st_q != ST_MEAS |=> st_q == ST_IDLE && left_q == PERIOD_LD;
   endproperty
   a_dis_idle: assert property (p_dis_idle) else $error("disabled monitor left idle");
   property p_dis_count;
      !en |=> g_attr[1].ops_q == $past(g_attr[1].ops_q) && g_attr[1].hist_q == $past(g_attr[1].hist_q);
   endproperty
   a_dis_count: assert property (p_dis_count) else $error("disabled monitor counted");
   // mode bit as a plain signal for the length check
   assign online_sel = ctrl_q[CTRL_ONLINE];
   property p_online_dur;
      st_q != ST_MEAS ##1 st_q == ST_MEAS |-> full_q == !$past(online_sel) &&
         dur_q == (full_q ? 32'(MEAS_FULL_MS) : 32'(MEAS_ONLINE_MS));
   endproperty
   a_online_dur: assert property (p_online_dur) else $error("wrong measurement length");
   property p_rtz;
      st_q == ST_IDLE && en && i_rtz |=> st_q == ST_MEAS && left_q == PERIOD_LD;
   endproperty
   a_rtz: assert property (p_rtz) else $error("return-to-zero did not start measure");
   property p_wait_idle;
      st_q == ST_WAIT && !i_bus_idle && !i_rtz && en |=> st_q == ST_WAIT;
   endproperty
   a_wait_idle: assert property (p_wait_idle) else $error("measure began on busy bus");
   property p_meas_hold;
      st_q == ST_MEAS && !(tick && dur_q == 32'h1) |=> st_q == ST_MEAS;
   endproperty
   a_meas_hold: assert property (p_meas_hold) else $error("measurement interrupted");
   property p_log;
      i_log_req && i_log_page == LOG_PAGE_TIME |=> o_log_valid && o_log_hit && o_log_data == $past(left_q);
   endproperty
   a_log: assert property (p_log) else $error("time left not reported");
   property p_sense;
      pred_q |=> o_sense == SENSE_PRED && pred_q;
   endproperty
   a_sense: assert property (p_sense) else $error("failure sense code lost");
   property p_clear;
      g_attr[0].done |=> g_attr[0].ops_q == '0 && g_attr[0].err_q == '0;
   endproperty
   a_clear: assert property (p_clear) else $error("interval counters not cleared");
   property p_hist_floor;
      g_attr[0].done && !g_attr[0].bad && g_attr[0].hist_q == '0 |=> g_attr[0].hist_q == '0;
   endproperty
   a_hist_floor: assert property (p_hist_floor) else $error("history went below zero");
   property p_pred;
      |pf_hit |=> pred_q && ist_q[INT_PRED];
   endproperty
   a_pred: assert property (p_pred) else $error("failure not signalled");

   c_meas: cover property (st_q == ST_WAIT ##1 st_q == ST_MEAS);
   c_rtz: cover property (st_q == ST_IDLE && i_rtz && en);
   c_pred: cover property (|pf_hit);
   c_irq: cover property (o_irq);
   c_offline: cover property (o_offline && o_meas);

   property p_wr_ctrl;
      wr && i_paddr == OFF_CTRL |=> {30'h0, ctrl_q} == ($past(i_pwdata) & 32'h3);
   endproperty
   a_wr_ctrl: assert property (p_wr_ctrl) else $error("control write lost");
   property p_ist_done;
      meas_done |=> ist_q[INT_DONE];
   endproperty
   a_ist_done: assert property (p_ist_done) else $error("measurement end not flagged");
   property p_int_clear;
      wr && i_paddr == OFF_INT_CLR && i_pwdata[INT_DONE] && !meas_done |=> !ist_q[INT_DONE];
   endproperty
   a_int_clear: assert property (p_int_clear) else $error("event flag not cleared");
   property p_nv_restore;
      !boot_q && i_nv_pred |=> pred_q && o_nv_pred;
   endproperty
   a_nv_restore: assert property (p_nv_restore) else $error("stored failure code not restored");
   property p_sched_wait;
      st_q == ST_IDLE && en && !i_rtz && tick && left_q == 32'h1 |=> st_q == ST_WAIT;
   endproperty
   a_sched_wait: assert property (p_sched_wait) else $error("due measurement not scheduled");
   property p_rtz_wait;
      st_q == ST_WAIT && en && i_rtz |=> st_q == ST_MEAS && left_q == PERIOD_LD;
   endproperty
   a_rtz_wait: assert property (p_rtz_wait) else $error("return-to-zero ignored while waiting");
   property p_meas_end;
      meas_done |=> st_q == ST_IDLE;
   endproperty
   a_meas_end: assert property (p_meas_end) else $error("measurement did not end");
   property p_hist_sat;
      g_attr[2].hist_q <= PRED_THR[2];
   endproperty
   a_hist_sat: assert property (p_hist_sat) else $error("history above threshold");
   property p_bad_up;
      g_attr[2].done && g_attr[2].bad && g_attr[2].hist_q != PRED_THR[2] |=> g_attr[2].hist_q == $past(g_attr[2].hist_q) + HIST_W'(1);
   endproperty
   a_bad_up: assert property (p_bad_up) else $error("history not raised");
   property p_hist_down;
      g_attr[0].done && !g_attr[0].bad && g_attr[0].hist_q != '0 |=> g_attr[0].hist_q == $past(g_attr[0].hist_q) - HIST_W'(1);
   endproperty
   a_hist_down: assert property (p_hist_down) else $error("history not lowered");
   property p_ops_count;
      g_attr[0].hit && !g_attr[0].done |=> g_attr[0].ops_q == $past(g_attr[0].ops_q) + OPS_W'(1);
   endproperty
   a_ops_count: assert property (p_ops_count) else $error("operation not counted");
   property p_log_miss;
      i_log_req && i_log_page != LOG_PAGE_TIME |=> o_log_valid && !o_log_hit && o_log_data == 32'h0;
   endproperty
   a_log_miss: assert property (p_log_miss) else $error("unknown page answered");
endmodule
`default_nettype wire

// >>> pfm_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// host initiator: bus idle level, return-to-zero pulses, log sense requests
module pfm_host_model (
   input  wire logic        i_mclk,      // device clock
   output logic             o_bus_idle,  // no host traffic
   output logic             o_rtz,       // return-to-zero pulse
   output logic             o_log_req,   // log sense strobe
   output logic [7:0]       o_log_page,  // requested page
   input  wire logic        i_log_valid, // answer strobe
   input  wire logic        i_log_hit,   // page known
   input  wire logic [31:0] i_log_data   // answer payload
);
   // start busy so the first scheduled measurement has to wait
   initial begin
      o_bus_idle = 1'b0;
      o_rtz      = 1'b0;
      o_log_req  = 1'b0;
      o_log_page = 8'h00;
   end
   // idle level changes only right after an edge
   task idle(input logic b);
      @(posedge i_mclk);
      o_bus_idle <= b;
   endtask
   task rtz;
      @(posedge i_mclk);
      o_rtz <= 1'b1;
      @(posedge i_mclk);
      o_rtz <= 1'b0;
   endtask
   // page is inverted once released so a stale value is never mistaken for a request
   task log_sense(input logic [7:0] pg, output logic hit, output logic [31:0] d);
      int k;
      @(posedge i_mclk);
      o_log_req  <= 1'b1;
      o_log_page <= pg;
      @(posedge i_mclk);
      o_log_req  <= 1'b0;
      o_log_page <= ~pg;
      hit = 1'bx;
      d   = 'x;
      k   = 0;
      while (i_log_valid !== 1'b1 && k < 8) begin
         @(posedge i_mclk);
         k++;
      end
      if (k < 8) begin
         hit = i_log_hit;
         d   = i_log_data;
      end
   endtask
endmodule
`default_nettype wire

// >>> test_predictive_failure_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module test_predictive_failure_monitor;
   import pfm_pkg::*;
   // short tick and period keep the run small; measurement lengths stay 65 and 490 ticks
   localparam int TK = 4;
   localparam int PT = 20;
   localparam int IL = 4;
   localparam int ET = 1;
   localparam int HT = 3;
   logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, nv_in = 1'b0;
   logic [7:0]  paddr = 8'h00, log_page;
   logic [31:0] pwdata = 32'h0, prdata, rd, log_data, ld;
   logic        pready, pslverr, er, hit, bus_idle, rtz, log_req, log_valid, log_hit, nv_out, meas, offline, irq;
   logic [23:0] sense;
   pfm_op_s     op = '0;
   int          n_errors = 0, num_checks = 0, n, a, ne, hist[4] = '{0, 0, 0, 0};
   bit          pred = 0, dis = 0;
   always #5 clk = ~clk;
   pfm_monitor #(.TICK_CYCLES(TK), .PERIOD_TICKS(PT), .INTERVAL_LEN('{default: 16'd4}),
      .ERR_THR('{default: 16'd1}), .PRED_THR('{default: 8'd3})) pfm_monitor_i (
      .i_mclk(clk), .i_sys_rst(rst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
      .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
      .i_op(op), .i_bus_idle(bus_idle), .i_rtz(rtz), .i_log_req(log_req), .i_log_page(log_page),
      .o_log_valid(log_valid), .o_log_hit(log_hit), .o_log_data(log_data), .i_nv_pred(nv_in),
      .o_nv_pred(nv_out), .o_sense(sense), .o_meas(meas), .o_offline(offline), .o_irq(irq));
   pfm_host_model pfm_host_model_i (.i_mclk(clk), .o_bus_idle(bus_idle), .o_rtz(rtz), .o_log_req(log_req),
      .o_log_page(log_page), .i_log_valid(log_valid), .i_log_hit(log_hit), .i_log_data(log_data));
   task finish_test;
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task chk(input string s, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         n_errors++;
         $display("unexpected %s: expected %h seen %h", s, e, g);
      end
   endtask
   // counted durations carry a tick of phase slack
   task near(input string s, input int e, input int g, input int t);
      num_checks++;
      if (g < e - t || g > e + t) begin
         n_errors++;
         $display("unexpected %s: expected %0d seen %0d", s, e, g);
      end
   endtask
   // apb master: setup, access held until pready, released right after that edge
   task apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
      int k;
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= ad;
      pwdata  <= wd;
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (k >= 20) begin
         n_errors++;
         finish_test;
      end
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      paddr   <= ~ad;
      pwdata  <= ~wd;
   endtask
   task rdc(input string s, input logic [7:0] ad, input logic [31:0] e);
      apb(1'b0, ad, 32'h0);
      chk(s, e, rd);
   endtask
   task wait_rise(input int lim);
      n = 0;
      while (meas !== 1'b1 && n < lim) begin
         @(posedge clk);
         n++;
      end
      if (n >= lim) begin
         n_errors++;
         finish_test;
      end
   endtask
   task meas_len(output int len);
      len = 0;
      while (meas === 1'b1 && len < 3000) begin
         @(posedge clk);
         len++;
      end
      if (len >= 3000) begin
         n_errors++;
         finish_test;
      end
   endtask
   // one whole interval, errors first; the reference model updates afterwards
   task interval(input int at, input int nerr);
      for (int k = 0; k < IL; k++) begin
         @(posedge clk);
         op <= '{valid: 1'b1, err: (k < nerr), attr: at[1:0]};
      end
      @(posedge clk);
      op <= '{valid: 1'b0, err: ~op.err, attr: ~op.attr};
      if (!dis) begin
         if (nerr > ET) hist[at] = (hist[at] < HT) ? hist[at] + 1 : HT;
         else if (hist[at] > 0) hist[at]--;
         if (hist[at] == HT) pred = 1;
      end
   endtask
   initial begin
      void'($urandom(32'h7241634e));
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      rdc("ctrl", OFF_CTRL, 32'h0);
      rdc("int_stat", OFF_INT_STAT, 32'h0);
      apb(1'b0, 8'h40, 32'h0);
      chk("slverr", 32'h1, {31'h0, er});
      chk("unmapped", 32'h0, rd);
      // bus busy: the due measurement must wait for idle
      repeat (PT * TK + 40) begin
         @(posedge clk);
         chk("meas_busy", 32'h0, {31'h0, meas});
      end
      rdc("status_wait", OFF_STATUS, 32'h2);
      pfm_host_model_i.idle(1'b1);
      wait_rise(6);
      chk("offline_full", 32'h1, {31'h0, offline});
      // bus busy again mid-save: the save must still run out
      pfm_host_model_i.idle(1'b0);
      meas_len(n);
      near("meas_full", 490 * TK, n, 2 * TK);
      rdc("int_done", OFF_INT_STAT, 32'h2);
      $display("test schedule done");
      // forced measurement in online-only mode, second request mid-run ignored
      apb(1'b1, OFF_CTRL, 32'h2);
      pfm_host_model_i.rtz;
      wait_rise(4);
      chk("offline_online", 32'h0, {31'h0, offline});
      apb(1'b0, OFF_TIME, 32'h0);
      near("time_reg", PT, int'(rd), 2);
      pfm_host_model_i.log_sense(LOG_PAGE_TIME, hit, ld);
      chk("log_hit", 32'h1, {31'h0, hit});
      near("log_time", PT, int'(ld), 2);
      pfm_host_model_i.rtz;
      meas_len(n);
      near("meas_online", 65 * TK, n, 4 * TK);
      pfm_host_model_i.log_sense(8'h3d, hit, ld);
      chk("log_miss", 32'h0, {31'h0, hit});
      chk("log_miss_data", 32'h0, ld);
      $display("test forced measurement done");
      // random intervals against the history model, then one attribute pushed to failure
      apb(1'b1, OFF_CTRL, 32'h0);
      apb(1'b1, OFF_INT_CLR, 32'h3);
      apb(1'b1, OFF_INT_EN, 32'h1);
      rdc("int_clear", OFF_INT_STAT, 32'h0);
      for (int i = 0; i < 16; i++) begin
         a  = (i == 0) ? 0 : (i < 8) ? $urandom % 4 : 2;
         ne = (i == 0) ? 0 : (i < 8) ? $urandom % 4 : 3;
         interval(a, ne);
         repeat (3) @(posedge clk);
         rdc("hist", OFF_HIST, {hist[3][7:0], hist[2][7:0], hist[1][7:0], hist[0][7:0]});
         chk("sense", pred ? {8'h0, SENSE_PRED} : 32'h0, {8'h0, sense});
         chk("irq", {31'h0, pred}, {31'h0, irq});
         chk("nv_pred", {31'h0, pred}, {31'h0, nv_out});
      end
      rdc("sense_reg", OFF_SENSE, {8'h0, SENSE_PRED});
      rdc("status_pred", OFF_STATUS, 32'h6);
      apb(1'b1, OFF_INT_EN, 32'h0);
      @(posedge clk);
      chk("irq_masked", 32'h0, {31'h0, irq});
      apb(1'b1, OFF_INT_EN, 32'h1);
      @(posedge clk);
      chk("irq_unmasked", 32'h1, {31'h0, irq});
      apb(1'b1, OFF_INT_CLR, 32'h1);
      rdc("int_cleared", OFF_INT_STAT, 32'h0);
      chk("irq_cleared", 32'h0, {31'h0, irq});
      $display("test history done");
      // disabled: operations and forced measurement both ignored
      apb(1'b1, OFF_CTRL, 32'h1);
      dis = 1;
      interval(1, 3);
      pfm_host_model_i.rtz;
      repeat (12) begin
         @(posedge clk);
         chk("meas_disabled", 32'h0, {31'h0, meas});
      end
      rdc("hist_disabled", OFF_HIST, {hist[3][7:0], hist[2][7:0], hist[1][7:0], hist[0][7:0]});
      $display("test disable done");
      // stored failure code restored across reset
      nv_in <= nv_out;
      rst   <= 1'b1;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      chk("sense_restored", {8'h0, SENSE_PRED}, {8'h0, sense});
      $display("test retention done");
      finish_test;
   end
   // hang guard, well beyond the expected run
   initial begin
      #900000;
      n_errors++;
      finish_test;
   end
endmodule
`default_nettype wire
